//--- core/tsc_defs.vh
// register offsets, field positions, reset values and timing constants for the touch scan block
`ifndef TSC_DEFS_VH
`define TSC_DEFS_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define TSC_OFS_SLOT_PRELOAD 4'h0
`define TSC_OFS_SCAN_CONTROL 4'h1
`define TSC_OFS_SCAN_CONFIG 4'h2
`define TSC_OFS_REF_COUNT_LOW 4'h3
`define TSC_OFS_REF_COUNT_HIGH 4'h4
`define TSC_OFS_KEY_COUNT_LOW 4'h5
`define TSC_OFS_KEY_COUNT_HIGH 4'h6
`define TSC_OFS_REF_CAP_LOW 4'h7
`define TSC_OFS_REF_CAP_HIGH 4'h8
`define TSC_OFS_MODULE_CONTROL_0 4'h9
`define TSC_OFS_MODULE_CONTROL_1 4'hA
`define TSC_OFS_SCAN_ORDER_SELECT 4'hB
`define TSC_OFS_MEM_ADDR 4'hC
`define TSC_OFS_MEM_DATA 4'hD
// ----------------------------------------
// scan_control field positions
// ----------------------------------------
`define TSC_BIT_MEM_ACCESS 7
`define TSC_BIT_SLOT_OVF 6
`define TSC_BIT_START 5
`define TSC_BIT_KEY_OVF 4
`define TSC_BIT_REF_OVF 3
`define TSC_BIT_MODE 1
`define TSC_BIT_BUSY 0
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define TSC_RST_SCAN_CONFIG 8'h03
`define TSC_UNIT_LAST 5'h1F
`define TSC_SLOT_LAST 8'hFF
`define TSC_KEY_SLOTS 3'h4
`endif

//--- core/tsc_scan_ctrl.v
// common scan controller of the capacitive touch key unit
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tsc_defs.vh"
module tsc_scan_ctrl #(
  parameter MEM_AW = 3  // touch memory address width, eight words, the key slots use the low four
) (
  input wire mclk_i,  // system clock, 50 MHz
  input wire nrst_i,  // asynchronous reset, active low
  input wire [3:0] addr_i,  // register index
  input wire [7:0] wdata_i,  // write data
  input wire wr_i,  // write strobe
  input wire rd_i,  // read strobe
  output reg [7:0] rdata_o,  // read data, one cycle after rd_i
  input wire slot_clk_i,  // time slot clock from pad side, asynchronous
  input wire key_clk_i,  // key oscillator clock, asynchronous
  input wire ref_clk_i,  // reference oscillator clock, asynchronous
  output reg key_osc_en_o,  // key oscillator run enable
  output reg ref_osc_en_o,  // reference oscillator run enable
  output reg [1:0] key_sel_o,  // key being scanned
  output reg [9:0] ref_cap_o,  // reference capacitor value to the pad
  output reg irq_req_o  // touch interrupt request flag, level
);
  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  reg [7:0] slot_preload;  // slot counter preload
  reg mem_access_select;  // memory owner when idle
  reg slot_overflow_flag;  // slot overflow flag
  reg scan_start;  // start bit
  reg key_count_overflow_flag;  // key counter overflow
  reg ref_count_overflow_flag;  // reference counter overflow
  reg scan_mode_select;  // 0 auto, 1 manual
  reg scan_busy_flag;  // scan running
  reg [7:0] scan_config;  // configuration, stored only
  reg [5:0] module_control_0;  // module control bits
  reg [7:0] module_control_1;  // module control bits
  reg [7:0] scan_order_select;  // four 2-bit order fields
  reg [9:0] ref_cap;  // reference capacitor value
  reg [15:0] key_count;  // key counter
  reg [15:0] ref_count;  // reference counter
  reg [4:0] unit_count;  // 5-bit unit counter
  reg [7:0] slot_count;  // 8-bit slot counter
  reg [2:0] key_idx;  // keys done in auto scan
  reg counting;  // counters switched on
  reg auto_owner;  // auto scan holds memory
  reg start_q;  // previous start bit
  reg [MEM_AW-1:0] mem_addr;  // cpu memory pointer
  reg [15:0] tmem [0:(1<<MEM_AW)-1];  // touch data memory, cap then result
  // input synchronisers, two flops each
  reg [2:0] sy1, sy2, sy3;  // first, second, third stages
  // oscillator pins are free running with respect to mclk_i
  // sy1 may go metastable, so only sy2 reads it
  // sy3 is a plain delay of sy2 used for edge detection
  // edge pulses are one mclk_i cycle wide
  // total latency from pin edge to tick is two cycles
  // each oscillator level must stand at least two cycles
  // faster oscillators would lose edges here
  wire slot_tick;
  wire key_tick;
  wire ref_tick;
  assign slot_tick = sy2[0] & ~sy3[0];
  assign key_tick = sy2[1] & ~sy3[1];
  assign ref_tick = sy2[2] & ~sy3[2];
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // order field for slot n
  // field 0 sits in bits 1:0, field 3 in bits 7:6
  // the result is a key number, also the memory word index
  function [1:0] order_key;
    input [7:0] sel;
    input [1:0] n;
    begin
      order_key = sel[2*n +: 2];
    end
  endfunction
  wire cpu_owns;
  assign cpu_owns = ~auto_owner & ~mem_access_select;
  wire wr_ctl;
  assign wr_ctl = wr_i & (addr_i == `TSC_OFS_SCAN_CONTROL);
  wire start_rise;
  assign start_rise = scan_start & ~start_q;
  wire unit_end;
  assign unit_end = counting & slot_tick & (unit_count == `TSC_UNIT_LAST);
  wire slot_ovf;
  assign slot_ovf = unit_end & (slot_count == `TSC_SLOT_LAST);
  wire last_key;
  assign last_key = (key_idx == (`TSC_KEY_SLOTS - 3'h1));
  wire auto_mode;
  assign auto_mode = ~scan_mode_select;
  wire [MEM_AW-1:0] slot_addr;
  assign slot_addr = {{(MEM_AW-2){1'b0}}, order_key(scan_order_select, key_idx[1:0])};
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // all three pins share one set of stages
  // bit 0 slot clock, bit 1 key clock, bit 2 reference clock
  // reset clears every stage so no false edge follows reset
  // the pad side holds its clocks low while stopped
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sy1 <= 3'h0;
      sy2 <= 3'h0;
      sy3 <= 3'h0;
    end else begin
      sy1 <= {ref_clk_i, key_clk_i, slot_clk_i};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end
  // ----------------------------------------
  // control register and scan sequencing
  // ----------------------------------------
  // one process owns every bit that both software and
  // hardware write, so later assignments decide priority
  // order inside the else branch:
  //   software writes first
  //   then start handling and counting
  //   hardware flag sets last, so a set wins over a clear
  // start low keeps the 16-bit and unit counters at zero
  // start rise is seen one cycle after the write lands
  // the slot counter keeps its value while start is low
  // busy may also be cleared by a software write of 0
  // a cleared busy does not stop a running scan
  // auto scans four slots, one per order field
  // manual stops at the first slot counter overflow
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_preload <= 8'h00;
      mem_access_select <= 1'b0;
      slot_overflow_flag <= 1'b0;
      scan_start <= 1'b0;
      key_count_overflow_flag <= 1'b0;
      ref_count_overflow_flag <= 1'b0;
      scan_mode_select <= 1'b0;
      scan_busy_flag <= 1'b0;
      irq_req_o <= 1'b0;
      start_q <= 1'b0;
      counting <= 1'b0;
      auto_owner <= 1'b0;
      key_idx <= 3'h0;
      key_count <= 16'h0000;
      ref_count <= 16'h0000;
      unit_count <= 5'h00;
      slot_count <= 8'h00;
      ref_cap <= 10'h000;
      key_osc_en_o <= 1'b0;
      ref_osc_en_o <= 1'b0;
      key_sel_o <= 2'h0;
    end else begin
      // previous start bit for edge detection
      start_q <= scan_start;
      // software writes to registers
      if (wr_i && addr_i == `TSC_OFS_SLOT_PRELOAD) begin
        slot_preload <= wdata_i;
      end
      if (wr_i && addr_i == `TSC_OFS_REF_CAP_LOW) begin
        ref_cap[7:0] <= wdata_i;
      end
      if (wr_i && addr_i == `TSC_OFS_REF_CAP_HIGH) begin
        ref_cap[9:8] <= wdata_i[1:0];
      end
      if (wr_ctl) begin
        mem_access_select <= wdata_i[`TSC_BIT_MEM_ACCESS];
        slot_overflow_flag <= wdata_i[`TSC_BIT_SLOT_OVF];
        scan_start <= wdata_i[`TSC_BIT_START];
        scan_mode_select <= wdata_i[`TSC_BIT_MODE];
        // software may only clear the key and reference overflow flags
        if (!wdata_i[`TSC_BIT_KEY_OVF]) begin
          key_count_overflow_flag <= 1'b0;
        end
        if (!wdata_i[`TSC_BIT_REF_OVF]) begin
          ref_count_overflow_flag <= 1'b0;
        end
        if (!wdata_i[`TSC_BIT_BUSY]) begin
          scan_busy_flag <= 1'b0;
        end
      end
      if (!scan_start) begin
        // start low: clear counters but not slot counter
        key_count <= 16'h0000;
        ref_count <= 16'h0000;
        unit_count <= 5'h00;
      end else if (start_rise) begin
        // scan begins: switch everything on
        counting <= 1'b1;
        key_osc_en_o <= 1'b1;
        ref_osc_en_o <= 1'b1;
        scan_busy_flag <= 1'b1;
        auto_owner <= auto_mode;
        key_idx <= 3'h0;
        slot_count <= slot_preload;
        if (auto_mode) begin
          ref_cap <= tmem[order_key(scan_order_select, 2'h0)][9:0];
          key_sel_o <= order_key(scan_order_select, 2'h0);
        end
      end else if (counting) begin
        // counters run on synchronised oscillator edges
        // a 16-bit wrap raises its overflow flag
        // the counter itself just rolls over to zero
        // unit counter wraps by itself after 31
        if (key_tick) begin
          key_count <= key_count + 16'h0001;
          if (key_count == 16'hFFFF) begin
            key_count_overflow_flag <= 1'b1;
          end
        end
        if (ref_tick) begin
          ref_count <= ref_count + 16'h0001;
          if (ref_count == 16'hFFFF) begin
            ref_count_overflow_flag <= 1'b1;
          end
        end
        if (slot_tick) begin
          unit_count <= unit_count + 5'h01;
        end
        if (unit_end && !slot_ovf) begin
          slot_count <= slot_count + 8'h01;
        end
        if (slot_ovf) begin
          if (auto_mode && !last_key) begin
            // slot finished, more keys left: result out, next cap in
            // the memory write of the result uses the old count
            // slot flag stays clear on this overflow
            key_count <= 16'h0000;
            ref_count <= 16'h0000;
            unit_count <= 5'h00;
            slot_count <= slot_preload;
            key_idx <= key_idx + 3'h1;
            key_sel_o <= order_key(scan_order_select, key_idx[1:0] + 2'h1);
            ref_cap <= tmem[order_key(scan_order_select, key_idx[1:0] + 2'h1)][9:0];
          end else begin
            // final overflow in either mode: stop and flag
            // counters keep their last value for software
            // memory returns to the access bit after this
            slot_overflow_flag <= 1'b1;
            irq_req_o <= 1'b1;
            counting <= 1'b0;
            key_osc_en_o <= 1'b0;
            ref_osc_en_o <= 1'b0;
            scan_busy_flag <= 1'b0;
            auto_owner <= 1'b0;
          end
        end
      end
      // irq clear via its own write; hardware set wins
      if (wr_i && addr_i == `TSC_OFS_MEM_ADDR && wdata_i[7] && !slot_ovf) begin
        irq_req_o <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  // scan_config and the module control bits are stored only and steer nothing here
  // unused module_control_1 bit 6 is kept at 0
  // the memory pointer takes only the low MEM_AW bits of the write
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_config <= `TSC_RST_SCAN_CONFIG;
      module_control_0 <= 6'h00;
      module_control_1 <= 8'h00;
      scan_order_select <= 8'h00;
      mem_addr <= {MEM_AW{1'b0}};
    end else if (wr_i) begin
      case (addr_i)
        `TSC_OFS_SCAN_CONFIG: scan_config <= wdata_i;
        `TSC_OFS_MODULE_CONTROL_0: module_control_0 <= wdata_i[5:0];
        `TSC_OFS_MODULE_CONTROL_1: module_control_1 <= {wdata_i[7], 1'b0, wdata_i[5:0]};
        `TSC_OFS_SCAN_ORDER_SELECT: scan_order_select <= wdata_i;
        `TSC_OFS_MEM_ADDR: mem_addr <= wdata_i[MEM_AW-1:0];
        default: mem_addr <= mem_addr;
      endcase
    end
  end
  // ----------------------------------------
  // touch data memory: cpu or scan port
  // ----------------------------------------
  // one write port; the scan side always wins
  // cpu writes are dropped while the scan owns memory
  // each word holds a cap value, later the key result
  // no reset: contents are whatever software loaded
  always @(posedge mclk_i) begin
    if (auto_owner && slot_ovf) begin
      // store this key's result at its slot
      tmem[slot_addr] <= key_count;
    end else if (wr_i && addr_i == `TSC_OFS_MEM_DATA && cpu_owns) begin
      tmem[mem_addr] <= {8'h00, wdata_i};
    end
  end
  // ----------------------------------------
  // read data and outputs
  // ----------------------------------------
  // read data stands for exactly one cycle after rd_i
  // and is zero in every other cycle
  // unmapped indices read zero
  // memory reads return zero while the scan owns it
  // the pointer register also shows the request flag
  // ref_cap_o trails the cap register by one cycle
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
      ref_cap_o <= 10'h000;
    end else begin
      ref_cap_o <= ref_cap;
      if (rd_i) begin
        case (addr_i)
          `TSC_OFS_SLOT_PRELOAD: rdata_o <= slot_preload;
          `TSC_OFS_SCAN_CONTROL: rdata_o <= {mem_access_select, slot_overflow_flag,
            scan_start, key_count_overflow_flag, ref_count_overflow_flag, 1'b0,
            scan_mode_select, scan_busy_flag};
          `TSC_OFS_SCAN_CONFIG: rdata_o <= scan_config;
          `TSC_OFS_REF_COUNT_LOW: rdata_o <= ref_count[7:0];
          `TSC_OFS_REF_COUNT_HIGH: rdata_o <= ref_count[15:8];
          `TSC_OFS_KEY_COUNT_LOW: rdata_o <= key_count[7:0];
          `TSC_OFS_KEY_COUNT_HIGH: rdata_o <= key_count[15:8];
          `TSC_OFS_REF_CAP_LOW: rdata_o <= ref_cap[7:0];
          `TSC_OFS_REF_CAP_HIGH: rdata_o <= {6'h00, ref_cap[9:8]};
          `TSC_OFS_MODULE_CONTROL_0: rdata_o <= {2'h0, module_control_0};
          `TSC_OFS_MODULE_CONTROL_1: rdata_o <= module_control_1;
          `TSC_OFS_SCAN_ORDER_SELECT: rdata_o <= scan_order_select;
          `TSC_OFS_MEM_ADDR: rdata_o <= {irq_req_o, {(7-MEM_AW){1'b0}}, mem_addr};
          `TSC_OFS_MEM_DATA: rdata_o <= cpu_owns ? tmem[mem_addr][7:0] : 8'h00;
          default: rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_touch_scan_control.sv
// self-checking testbench for the touch scan controller
`timescale 1ns/10ps
`default_nettype none
`include "tsc_defs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("FAIL at %0t got %h exp %h", $time, (a), (e)); end end
module tb_touch_scan_control;
  logic mclk_i = 1'b0;  // 50 MHz system clock
  logic nrst_i = 1'b0;  // reset, active low
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o, v1, v2;
  logic key_osc_en_o, ref_osc_en_o, slot_clk, key_clk, ref_clk, irq_req_o;
  logic [1:0] key_sel_o;
  logic [9:0] ref_cap_o;
  int n_mismatch = 0;
  int tests_run = 0;
  always #10 mclk_i = ~mclk_i;
  tsc_scan_ctrl u_tsc_scan_ctrl (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slot_clk_i(slot_clk),
    .key_clk_i(key_clk), .ref_clk_i(ref_clk), .key_osc_en_o(key_osc_en_o),
    .ref_osc_en_o(ref_osc_en_o), .key_sel_o(key_sel_o), .ref_cap_o(ref_cap_o),
    .irq_req_o(irq_req_o));
  tsc_pad_model u_tsc_pad_model (.mclk_i(mclk_i), .key_en_i(key_osc_en_o),
    .ref_en_i(ref_osc_en_o), .slot_clk_o(slot_clk), .key_clk_o(key_clk), .ref_clk_o(ref_clk));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the oscillators to stop
  task automatic wait_end;
    int i;
    for (i = 0; i < 5000 && ref_osc_en_o !== 1'b0; i++) @(posedge mclk_i);
    `CHK(ref_osc_en_o, 1'b0)
    if (i == 5000) test_done;
    repeat (3) @(posedge mclk_i);
  endtask
  initial begin
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rdc(`TSC_OFS_SLOT_PRELOAD, 8'h00);
    rdc(`TSC_OFS_SCAN_CONTROL, 8'h00);
    rdc(`TSC_OFS_SCAN_CONFIG, `TSC_RST_SCAN_CONFIG);
    rdc(4'hE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`TSC_OFS_MEM_ADDR, 8'(k));
      wr(`TSC_OFS_MEM_DATA, 8'hA0 + 8'(k));
    end
    rdc(`TSC_OFS_MEM_DATA, 8'hA3);
    wr(`TSC_OFS_SCAN_CONTROL, 8'h86);
    rdc(`TSC_OFS_SCAN_CONTROL, 8'h82);
    rdc(`TSC_OFS_MEM_DATA, 8'h00);
    wr(`TSC_OFS_MEM_DATA, 8'h55);
    wr(`TSC_OFS_SCAN_CONTROL, 8'h02);
    rdc(`TSC_OFS_MEM_DATA, 8'hA3);
    $display("test registers done");
    wr(`TSC_OFS_SLOT_PRELOAD, 8'hFE);
    wr(`TSC_OFS_REF_CAP_LOW, 8'h3C);
    wr(`TSC_OFS_SCAN_CONTROL, 8'h22);
    rdc(`TSC_OFS_SCAN_CONTROL, 8'h23);
    `CHK(ref_cap_o, 10'h03C)
    wr(`TSC_OFS_SCAN_CONTROL, 8'h22);
    wait_end;
    rdc(`TSC_OFS_SCAN_CONTROL, 8'h62);
    `CHK(irq_req_o, 1'b1)
    rd(`TSC_OFS_REF_COUNT_LOW, v1);
    repeat (20) @(posedge mclk_i);
    rd(`TSC_OFS_REF_COUNT_LOW, v2);
    `CHK(v2, v1)
    wr(`TSC_OFS_SCAN_CONTROL, 8'h02);
    rdc(`TSC_OFS_REF_COUNT_LOW, 8'h00);
    rdc(`TSC_OFS_KEY_COUNT_LOW, 8'h00);
    rdc(`TSC_OFS_SLOT_PRELOAD, 8'hFE);
    $display("test manual scan done");
    wr(`TSC_OFS_MEM_ADDR, 8'h80);
    `CHK(irq_req_o, 1'b0)
    wr(`TSC_OFS_SCAN_CONTROL, 8'h42);
    rdc(`TSC_OFS_SCAN_CONTROL, 8'h42);
    `CHK(irq_req_o, 1'b0)
    $display("test flag write done");
    wr(`TSC_OFS_SCAN_CONTROL, 8'h00);
    wr(`TSC_OFS_SCAN_ORDER_SELECT, 8'h1E);
    wr(`TSC_OFS_SCAN_CONTROL, 8'h20);
    repeat (100) @(posedge mclk_i);
    rdc(`TSC_OFS_MEM_DATA, 8'h00);
    `CHK(ref_cap_o, 10'h0A2)
    wr(`TSC_OFS_SCAN_CONTROL, 8'hA0);
    wait_end;
    rdc(`TSC_OFS_SCAN_CONTROL, 8'hE0);
    `CHK(irq_req_o, 1'b1)
    `CHK(ref_cap_o, 10'h0A0)
    $display("test auto scan done");
    test_done;
  end
endmodule
`default_nettype wire

//--- verif/tsc_pad_model.sv
// touch pad oscillator model: key and reference clocks, slot clock from reference
`timescale 1ns/10ps
`default_nettype none
module tsc_pad_model #(
  parameter int HALF_REF = 4,  // reference half period in system cycles
  parameter int HALF_KEY = 3  // key half period in system cycles
) (
  input wire logic mclk_i,
  input wire logic key_en_i,
  input wire logic ref_en_i,
  output logic slot_clk_o,
  output logic key_clk_o,
  output logic ref_clk_o
);
  int rc = 0;  // reference phase count
  int kc = 0;  // key phase count
  initial begin
    key_clk_o = 1'b0;
    ref_clk_o = 1'b0;
  end
  // oscillators run only while enabled, stand low otherwise
  always @(posedge mclk_i) begin
    if (!ref_en_i) begin
      rc <= 0;
      ref_clk_o <= 1'b0;
    end else if (rc == HALF_REF - 1) begin
      rc <= 0;
      ref_clk_o <= !ref_clk_o;
    end else rc <= rc + 1;
    if (!key_en_i) begin
      kc <= 0;
      key_clk_o <= 1'b0;
    end else if (kc == HALF_KEY - 1) begin
      kc <= 0;
      key_clk_o <= !key_clk_o;
    end else kc <= kc + 1;
  end
  assign slot_clk_o = ref_clk_o;  // slots timed by reference oscillator
endmodule
`default_nettype wire

//--- verif/tsc_scan_props.sv
// port checker for the touch scan controller
`timescale 1ns/10ps
`default_nettype none
`include "tsc_defs.vh"
module tsc_scan_props (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic slot_clk_i,
  input wire logic key_clk_i,
  input wire logic ref_clk_i,
  input wire logic key_osc_en_o,
  input wire logic ref_osc_en_o,
  input wire logic [1:0] key_sel_o,
  input wire logic [9:0] ref_cap_o,
  input wire logic irq_req_o
);
  // ----------------------------------------
  // shadow of software settings
  // ----------------------------------------
  logic start_sh;  // last written start bit
  logic mode_sh;  // last written mode bit
  logic slot_q;  // slot clock one cycle back
  logic [7:0] pre_sh;  // preload copy
  logic [7:0] ord_sh;  // order fields copy
  logic [15:0] ecnt;  // slot edges since start
  wire ctl_wr = wr_i && addr_i == `TSC_OFS_SCAN_CONTROL;
  wire rise = ctl_wr && wdata_i[5] && !start_sh;
  wire [15:0] per = (16'h0100 - {8'h00, pre_sh}) << 5;
  wire [15:0] slot_no = ecnt / per;
  wire [7:0] fld = ord_sh >> {slot_no[1:0], 1'b0};
  // track writes and count slot clock edges while running
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_sh <= 1'b0;
      mode_sh <= 1'b0;
      slot_q <= 1'b0;
      pre_sh <= 8'h00;
      ord_sh <= 8'h00;
      ecnt <= 16'h0000;
    end else begin
      slot_q <= slot_clk_i;
      if (ctl_wr) begin
        start_sh <= wdata_i[5];
        mode_sh <= wdata_i[1];
      end
      if (wr_i && addr_i == `TSC_OFS_SLOT_PRELOAD) pre_sh <= wdata_i;
      if (wr_i && addr_i == `TSC_OFS_SCAN_ORDER_SELECT) ord_sh <= wdata_i;
      if (rise) ecnt <= 16'h0000;
      else if (ref_osc_en_o && slot_clk_i && !slot_q) ecnt <= ecnt + 16'h0001;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  chk_start_osc_on: assert property (rise |-> ##[1:2] (key_osc_en_o && ref_osc_en_o))
    else $error("oscillators not started");
  chk_manual_len: assert property ($fell(ref_osc_en_o) && start_sh && mode_sh |-> ecnt == per)
    else $error("manual scan length wrong");
  chk_auto_len: assert property ($fell(ref_osc_en_o) && start_sh && !mode_sh |-> ecnt == per << 2)
    else $error("auto scan length wrong");
  chk_end_irq: assert property ($fell(ref_osc_en_o) && start_sh |-> ##[0:1] irq_req_o)
    else $error("no request at scan end");
  chk_end_key_off: assert property ($fell(ref_osc_en_o) |-> ##[0:1] !key_osc_en_o)
    else $error("key oscillator left running");
  chk_sw_ovf_quiet: assert property (ctl_wr && wdata_i[6] && !ref_osc_en_o && !irq_req_o
    |=> !irq_req_o)
    else $error("software flag write raised request");
  chk_bit2_zero: assert property (rd_i && addr_i == `TSC_OFS_SCAN_CONTROL |=> !rdata_o[2])
    else $error("unused control bit read as one");
  chk_key_order: assert property (ref_osc_en_o && start_sh && !mode_sh && ecnt % per == per >> 1
    |-> key_sel_o == fld[1:0])
    else $error("key scanned out of order");
  cover property ($fell(ref_osc_en_o) && mode_sh);
  cover property ($fell(ref_osc_en_o) && !mode_sh);
  cover property (ctl_wr && wdata_i[6] && !irq_req_o);
endmodule
bind tsc_scan_ctrl tsc_scan_props u_tsc_scan_props (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .slot_clk_i(slot_clk_i), .key_clk_i(key_clk_i), .ref_clk_i(ref_clk_i),
  .key_osc_en_o(key_osc_en_o), .ref_osc_en_o(ref_osc_en_o), .key_sel_o(key_sel_o),
  .ref_cap_o(ref_cap_o), .irq_req_o(irq_req_o));
`default_nettype wire
